/* File: design/rgbmod_defs.vh */
`ifndef RGBMOD_DEFS_VH
`define RGBMOD_DEFS_VH

// register byte offsets
`define RGBMOD_ADDR_W 8
`define RGBMOD_OFS_CTRL 8'h00
`define RGBMOD_OFS_PERIOD 8'h04
`define RGBMOD_OFS_DUTY_R 8'h08
`define RGBMOD_OFS_DUTY_G 8'h0C
`define RGBMOD_OFS_DUTY_B 8'h10
`define RGBMOD_OFS_PDM_RATE 8'h14
`define RGBMOD_OFS_PDM_VAL 8'h18
`define RGBMOD_OFS_STATUS 8'h1C
`define RGBMOD_OFS_INT_EN 8'h20
`define RGBMOD_OFS_INT_CLR 8'h24
`define RGBMOD_OFS_TIMER 8'h28
`define RGBMOD_OFS_ACTIVE 8'h2C

// widths
`define RGBMOD_CNT_W 16
`define RGBMOD_COLOR_W 8
`define RGBMOD_ACC_W 16
`define RGBMOD_EVT_W 2
`define RGBMOD_CTRL_W 2
`define RGBMOD_VAL_W 24

// control fields
`define RGBMOD_CTRL_EN 0
`define RGBMOD_CTRL_MODE 1

// event / status fields
`define RGBMOD_EVT_WRAP 0
`define RGBMOD_EVT_TICK 1

// color value fields in the pdm value register
`define RGBMOD_VAL_R 7:0
`define RGBMOD_VAL_G 15:8
`define RGBMOD_VAL_B 23:16

// carry position of the pdm accumulator (ninth bit)
`define RGBMOD_ACC_CARRY 8

// reset values
`define RGBMOD_RST_CNT 16'h0000
`define RGBMOD_RST_PERIOD 16'h00FF
`define RGBMOD_RST_RATE 16'h00FF
`define RGBMOD_RST_WORD 32'h00000000
`define RGBMOD_RST_CTRL 2'h0
`define RGBMOD_RST_VAL 24'h000000
`define RGBMOD_RST_EVT 2'h0
`define RGBMOD_CNT_ONE 16'h0001

`endif

/* File: design/rgbmod_compare.v */
`timescale 1ns/100ps
`default_nettype none
`include "rgbmod_defs.vh"

// one output compare unit on the shared period timer
module rgbmod_compare (
    input wire pclk,
    input wire presetn,
    input wire run,
    input wire wrap,
    input wire [`RGBMOD_CNT_W-1:0] timer_nxt,
    input wire [`RGBMOD_CNT_W-1:0] duty_buffer_reg,
    output reg [`RGBMOD_CNT_W-1:0] duty_active_reg,
    output reg compare_output_pin
);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_active_reg <= `RGBMOD_RST_CNT;
            compare_output_pin <= 1'b0;
        end else if (!run) begin
            compare_output_pin <= 1'b0;
        end else if (wrap) begin
            // reload and go high, unless the new duty is zero
            duty_active_reg <= duty_buffer_reg;
            compare_output_pin <= (duty_buffer_reg != `RGBMOD_RST_CNT);
        end else if (timer_nxt == duty_active_reg) begin
            compare_output_pin <= 1'b0;
        end
    end
endmodule // rgbmod_compare

`default_nettype wire

/* File: design/rgbmod_accum.v */
`timescale 1ns/100ps
`default_nettype none
`include "rgbmod_defs.vh"

// one pdm accumulator with carry output
module rgbmod_accum (
    input wire pclk,
    input wire presetn,
    input wire run,
    input wire tick,
    input wire [`RGBMOD_COLOR_W-1:0] color,
    output reg carry_out
);
    reg [`RGBMOD_ACC_W-1:0] acc_ff;
    wire [`RGBMOD_ACC_W-1:0] sum;

    assign sum = acc_ff + {{(`RGBMOD_ACC_W-`RGBMOD_COLOR_W){1'b0}}, color};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_ff <= `RGBMOD_RST_CNT;
            carry_out <= 1'b0;
        end else if (!run) begin
            acc_ff <= `RGBMOD_RST_CNT;
            carry_out <= 1'b0;
        end else if (tick) begin
            carry_out <= sum[`RGBMOD_ACC_CARRY];
            acc_ff <= {{(`RGBMOD_ACC_W-`RGBMOD_COLOR_W){1'b0}}, sum[`RGBMOD_COLOR_W-1:0]};
        end
    end
endmodule // rgbmod_accum

`default_nettype wire

/* File: design/rgbmod_top.v */
`timescale 1ns/100ps
`default_nettype none
`include "rgbmod_defs.vh"

module rgbmod_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`RGBMOD_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg irq,
    output reg red_drive,
    output reg green_drive,
    output reg blue_drive
);
    // software visible state
    reg [`RGBMOD_CTRL_W-1:0] ctrl_ff;
    reg [`RGBMOD_CNT_W-1:0] period_limit_reg;
    reg [`RGBMOD_CNT_W-1:0] duty_buf_r_ff;
    reg [`RGBMOD_CNT_W-1:0] duty_buf_g_ff;
    reg [`RGBMOD_CNT_W-1:0] duty_buf_b_ff;
    reg [`RGBMOD_CNT_W-1:0] pdm_rate_ff;
    reg [`RGBMOD_VAL_W-1:0] pdm_val_ff;
    reg [`RGBMOD_EVT_W-1:0] status_ff;
    reg [`RGBMOD_EVT_W-1:0] int_en_ff;

    // timers
    reg [`RGBMOD_CNT_W-1:0] timer_ff;
    reg [`RGBMOD_CNT_W-1:0] nxt_timer;
    reg [`RGBMOD_CNT_W-1:0] tick_cnt_ff;
    reg [`RGBMOD_CNT_W-1:0] nxt_tick_cnt;
    reg wrap;
    reg tick;

    // bus decode
    wire setup_ph;
    wire wr_en;
    reg addr_ok;
    reg [31:0] nxt_prdata;

    wire run;
    wire pwm_run;
    wire pdm_run;
    wire [`RGBMOD_CNT_W-1:0] active_r;
    wire [`RGBMOD_CNT_W-1:0] active_g;
    wire [`RGBMOD_CNT_W-1:0] active_b;
    wire pwm_r;
    wire pwm_g;
    wire pwm_b;
    wire pdm_r;
    wire pdm_g;
    wire pdm_b;
    wire [`RGBMOD_EVT_W-1:0] evt;
    wire [`RGBMOD_EVT_W-1:0] clr;
    wire [`RGBMOD_EVT_W-1:0] period_wrap_flag;
    wire clr_hit;
    reg nxt_red;
    reg nxt_green;
    reg nxt_blue;

    assign setup_ph = psel & ~penable;
    assign wr_en = psel & penable & pready & pwrite & addr_ok;
    assign run = ctrl_ff[`RGBMOD_CTRL_EN];
    assign pwm_run = run & ~ctrl_ff[`RGBMOD_CTRL_MODE];
    assign pdm_run = run & ctrl_ff[`RGBMOD_CTRL_MODE];

    // address decode
    always @* begin
        case (paddr)
            `RGBMOD_OFS_CTRL,
            `RGBMOD_OFS_PERIOD,
            `RGBMOD_OFS_DUTY_R,
            `RGBMOD_OFS_DUTY_G,
            `RGBMOD_OFS_DUTY_B,
            `RGBMOD_OFS_PDM_RATE,
            `RGBMOD_OFS_PDM_VAL,
            `RGBMOD_OFS_STATUS,
            `RGBMOD_OFS_INT_EN,
            `RGBMOD_OFS_INT_CLR,
            `RGBMOD_OFS_TIMER,
            `RGBMOD_OFS_ACTIVE: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // read mux
    always @* begin
        nxt_prdata = `RGBMOD_RST_WORD;
        case (paddr)
            `RGBMOD_OFS_CTRL: nxt_prdata[`RGBMOD_CTRL_W-1:0] = ctrl_ff;
            `RGBMOD_OFS_PERIOD: nxt_prdata[`RGBMOD_CNT_W-1:0] = period_limit_reg;
            `RGBMOD_OFS_DUTY_R: nxt_prdata[`RGBMOD_CNT_W-1:0] = duty_buf_r_ff;
            `RGBMOD_OFS_DUTY_G: nxt_prdata[`RGBMOD_CNT_W-1:0] = duty_buf_g_ff;
            `RGBMOD_OFS_DUTY_B: nxt_prdata[`RGBMOD_CNT_W-1:0] = duty_buf_b_ff;
            `RGBMOD_OFS_PDM_RATE: nxt_prdata[`RGBMOD_CNT_W-1:0] = pdm_rate_ff;
            `RGBMOD_OFS_PDM_VAL: nxt_prdata[`RGBMOD_VAL_W-1:0] = pdm_val_ff;
            `RGBMOD_OFS_STATUS: nxt_prdata[`RGBMOD_EVT_W-1:0] = status_ff;
            `RGBMOD_OFS_INT_EN: nxt_prdata[`RGBMOD_EVT_W-1:0] = int_en_ff;
            `RGBMOD_OFS_TIMER: nxt_prdata[`RGBMOD_CNT_W-1:0] = timer_ff;
            `RGBMOD_OFS_ACTIVE: nxt_prdata[`RGBMOD_CNT_W-1:0] = active_r;
            default: nxt_prdata = `RGBMOD_RST_WORD;
        endcase
    end

    // apb answer: one wait-free access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `RGBMOD_RST_WORD;
        end else begin
            pready <= setup_ph;
            pslverr <= setup_ph & ~addr_ok;
            if (setup_ph && !pwrite) begin
                prdata <= nxt_prdata;
            end else if (setup_ph) begin
                prdata <= `RGBMOD_RST_WORD;
            end
        end
    end

    // register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `RGBMOD_RST_CTRL;
            period_limit_reg <= `RGBMOD_RST_PERIOD;
            duty_buf_r_ff <= `RGBMOD_RST_CNT;
            duty_buf_g_ff <= `RGBMOD_RST_CNT;
            duty_buf_b_ff <= `RGBMOD_RST_CNT;
            pdm_rate_ff <= `RGBMOD_RST_RATE;
            pdm_val_ff <= `RGBMOD_RST_VAL;
            int_en_ff <= `RGBMOD_RST_EVT;
        end else if (wr_en) begin
            case (paddr)
                `RGBMOD_OFS_CTRL: ctrl_ff <= pwdata[`RGBMOD_CTRL_W-1:0];
                `RGBMOD_OFS_PERIOD: period_limit_reg <= pwdata[`RGBMOD_CNT_W-1:0];
                `RGBMOD_OFS_DUTY_R: duty_buf_r_ff <= pwdata[`RGBMOD_CNT_W-1:0];
                `RGBMOD_OFS_DUTY_G: duty_buf_g_ff <= pwdata[`RGBMOD_CNT_W-1:0];
                `RGBMOD_OFS_DUTY_B: duty_buf_b_ff <= pwdata[`RGBMOD_CNT_W-1:0];
                `RGBMOD_OFS_PDM_RATE: pdm_rate_ff <= pwdata[`RGBMOD_CNT_W-1:0];
                `RGBMOD_OFS_PDM_VAL: pdm_val_ff <= pwdata[`RGBMOD_VAL_W-1:0];
                `RGBMOD_OFS_INT_EN: int_en_ff <= pwdata[`RGBMOD_EVT_W-1:0];
                default: int_en_ff <= int_en_ff;
            endcase
        end
    end

    // shared period timer
    always @* begin
        wrap = pwm_run & (timer_ff >= period_limit_reg);
        if (!pwm_run || wrap) begin
            nxt_timer = `RGBMOD_RST_CNT;
        end else begin
            nxt_timer = timer_ff + `RGBMOD_CNT_ONE;
        end
    end

    // separate pdm tick timer
    always @* begin
        tick = pdm_run & (tick_cnt_ff >= pdm_rate_ff);
        if (!pdm_run || tick) begin
            nxt_tick_cnt = `RGBMOD_RST_CNT;
        end else begin
            nxt_tick_cnt = tick_cnt_ff + `RGBMOD_CNT_ONE;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_ff <= `RGBMOD_RST_CNT;
            tick_cnt_ff <= `RGBMOD_RST_CNT;
        end else begin
            timer_ff <= nxt_timer;
            tick_cnt_ff <= nxt_tick_cnt;
        end
    end

    // three compare units on the one timer
    rgbmod_compare u_cmp_r (
        .pclk(pclk),
        .presetn(presetn),
        .run(pwm_run),
        .wrap(wrap),
        .timer_nxt(nxt_timer),
        .duty_buffer_reg(duty_buf_r_ff),
        .duty_active_reg(active_r),
        .compare_output_pin(pwm_r)
    );

    rgbmod_compare u_cmp_g (
        .pclk(pclk),
        .presetn(presetn),
        .run(pwm_run),
        .wrap(wrap),
        .timer_nxt(nxt_timer),
        .duty_buffer_reg(duty_buf_g_ff),
        .duty_active_reg(active_g),
        .compare_output_pin(pwm_g)
    );

    rgbmod_compare u_cmp_b (
        .pclk(pclk),
        .presetn(presetn),
        .run(pwm_run),
        .wrap(wrap),
        .timer_nxt(nxt_timer),
        .duty_buffer_reg(duty_buf_b_ff),
        .duty_active_reg(active_b),
        .compare_output_pin(pwm_b)
    );

    // three pdm accumulators
    rgbmod_accum u_acc_r (
        .pclk(pclk),
        .presetn(presetn),
        .run(pdm_run),
        .tick(tick),
        .color(pdm_val_ff[`RGBMOD_VAL_R]),
        .carry_out(pdm_r)
    );

    rgbmod_accum u_acc_g (
        .pclk(pclk),
        .presetn(presetn),
        .run(pdm_run),
        .tick(tick),
        .color(pdm_val_ff[`RGBMOD_VAL_G]),
        .carry_out(pdm_g)
    );

    rgbmod_accum u_acc_b (
        .pclk(pclk),
        .presetn(presetn),
        .run(pdm_run),
        .tick(tick),
        .color(pdm_val_ff[`RGBMOD_VAL_B]),
        .carry_out(pdm_b)
    );

    // sticky events, set wins over clear
    assign evt = {tick, wrap};
    assign clr_hit = wr_en & (paddr == `RGBMOD_OFS_INT_CLR);
    assign clr = clr_hit ? pwdata[`RGBMOD_EVT_W-1:0] : `RGBMOD_RST_EVT;
    assign period_wrap_flag = (status_ff & ~clr) | evt;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= `RGBMOD_RST_EVT;
            irq <= 1'b0;
        end else begin
            status_ff <= period_wrap_flag;
            irq <= |(period_wrap_flag & int_en_ff);
        end
    end

    // colour source select
    always @* begin
        if (ctrl_ff[`RGBMOD_CTRL_MODE]) begin
            nxt_red = pdm_r;
            nxt_green = pdm_g;
            nxt_blue = pdm_b;
        end else begin
            nxt_red = pwm_r;
            nxt_green = pwm_g;
            nxt_blue = pwm_b;
        end
    end

    // colour lines, one per component
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            red_drive <= 1'b0;
            green_drive <= 1'b0;
            blue_drive <= 1'b0;
        end else begin
            red_drive <= nxt_red;
            green_drive <= nxt_green;
            blue_drive <= nxt_blue;
        end
    end
endmodule // rgbmod_top

`default_nettype wire

/* File: testbench/rgbmod_top_checker.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rgbmod_defs.vh"

module rgbmod_top_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic red_drive,
    input wire logic green_drive,
    input wire logic blue_drive
);
    logic en_ff;
    logic [1:0] ie_ff;
    logic [1:0] off_ff;
    logic wr_done;
    logic any_on;
    assign wr_done = psel && penable && pready && pwrite;
    assign any_on = red_drive || green_drive || blue_drive;
    // shadow of enable bits and cycles spent disabled
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff <= 1'b0;
            ie_ff <= 2'b00;
            off_ff <= 2'b00;
        end else begin
            if (wr_done && paddr == `RGBMOD_OFS_CTRL) en_ff <= pwdata[0];
            if (wr_done && paddr == `RGBMOD_OFS_INT_EN) ie_ff <= pwdata[1:0];
            off_ff <= en_ff ? 2'b00 : (off_ff == 2'b11 ? 2'b11 : off_ff + 2'b01);
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    ready_single_a: assert property (pready |=> !pready) else $error("ready held too long");
    err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    unmapped_err_a: assert property (pready && (paddr > `RGBMOD_OFS_ACTIVE || paddr[1:0] != 2'b00) |-> pslverr)
        else $error("no error");
    mapped_ok_a: assert property (pready && paddr <= `RGBMOD_OFS_ACTIVE && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("bad error");
    write_rdata_a: assert property (pready && pwrite |-> prdata == 32'h00000000) else $error("data on write");
    reset_low_a: assert property ($rose(presetn) |-> !any_on) else $error("drive after reset");
    off_low_a: assert property (off_ff == 2'b11 |-> !any_on) else $error("drive while disabled");
    irq_enable_a: assert property (irq |-> ie_ff != 2'b00 || $past(ie_ff) != 2'b00) else $error("irq masked");
endmodule // rgbmod_top_checker

bind rgbmod_top rgbmod_top_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .red_drive(red_drive), .green_drive(green_drive), .blue_drive(blue_drive));
`default_nettype wire

/* File: testbench/rgbmod_led.sv */
`timescale 1ns/100ps
`default_nettype none

// passive lamp: integrates on-time of each colour line
module rgbmod_led (
    input wire logic pclk,
    input wire logic clr,
    input wire logic red_drive,
    input wire logic green_drive,
    input wire logic blue_drive,
    output var logic [15:0] cnt_r,
    output var logic [15:0] cnt_g,
    output var logic [15:0] cnt_b
);
    always @(posedge pclk) begin
        if (clr) begin
            cnt_r <= 16'h0000;
            cnt_g <= 16'h0000;
            cnt_b <= 16'h0000;
        end else begin
            cnt_r <= cnt_r + {15'h0000, red_drive};
            cnt_g <= cnt_g + {15'h0000, green_drive};
            cnt_b <= cnt_b + {15'h0000, blue_drive};
        end
    end
endmodule // rgbmod_led
`default_nettype wire

/* File: testbench/rgbmod_top_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rgbmod_defs.vh"

module rgbmod_top_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic clr = 1'b0;
    logic err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, irq, red_drive, green_drive, blue_drive;
    logic [15:0] cnt_r, cnt_g, cnt_b;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;

    rgbmod_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .red_drive(red_drive), .green_drive(green_drive), .blue_drive(blue_drive));
    rgbmod_led led (.pclk(pclk), .clr(clr), .red_drive(red_drive), .green_drive(green_drive),
        .blue_drive(blue_drive), .cnt_r(cnt_r), .cnt_g(cnt_g), .cnt_b(cnt_b));

    initial forever #10 pclk = ~pclk;

    task test_done;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // clear lamp counters, then integrate n cycles
    task win(input int n);
        @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task t_reset;
        chk({red_drive, green_drive, blue_drive}, 0);
        apb(1'b0, `RGBMOD_OFS_CTRL, 0);
        chk(rd, 0);
        apb(1'b0, `RGBMOD_OFS_PERIOD, 0);
        chk(rd, 32'h000000FF);
        apb(1'b0, `RGBMOD_OFS_PDM_RATE, 0);
        chk(rd, 32'h000000FF);
        apb(1'b0, `RGBMOD_OFS_TIMER, 0);
        chk(rd, 0);
        apb(1'b0, `RGBMOD_OFS_ACTIVE, 0);
        chk(rd, 0);
        apb(1'b0, 8'h40, 0);
        chk(err, 1);
        chk(rd, 0);
        apb(1'b0, 8'h05, 0);
        chk(err, 1);
    endtask

    task t_pwm;
        apb(1'b1, `RGBMOD_OFS_PERIOD, 9);
        apb(1'b1, `RGBMOD_OFS_DUTY_R, 3);
        apb(1'b1, `RGBMOD_OFS_DUTY_G, 0);
        apb(1'b1, `RGBMOD_OFS_DUTY_B, 12);
        apb(1'b1, `RGBMOD_OFS_INT_EN, 1);
        apb(1'b1, `RGBMOD_OFS_CTRL, 1);
        repeat (25) @(posedge pclk);
        win(30);
        chk(cnt_r, 9);
        chk(cnt_g, 0);
        chk(cnt_b, 30);
        chk(irq, 1);
        apb(1'b0, `RGBMOD_OFS_STATUS, 0);
        chk(rd[0], 1);
        apb(1'b1, `RGBMOD_OFS_DUTY_R, 6);
        repeat (25) @(posedge pclk);
        win(30);
        chk(cnt_r, 18);
        apb(1'b0, `RGBMOD_OFS_ACTIVE, 0);
        chk(rd, 6);
        apb(1'b0, `RGBMOD_OFS_TIMER, 0);
        chk(rd <= 9, 1);
    endtask

    task t_off;
        apb(1'b1, `RGBMOD_OFS_CTRL, 0);
        repeat (3) @(posedge pclk);
        #1;
        chk({red_drive, green_drive, blue_drive}, 0);
        apb(1'b1, `RGBMOD_OFS_INT_CLR, 3);
        apb(1'b1, `RGBMOD_OFS_STATUS, 3);
        apb(1'b0, `RGBMOD_OFS_STATUS, 0);
        chk(rd, 0);
        repeat (2) @(posedge pclk);
        #1;
        chk(irq, 0);
    endtask

    task t_pdm;
        apb(1'b1, `RGBMOD_OFS_PDM_RATE, 1);
        apb(1'b1, `RGBMOD_OFS_PDM_VAL, 32'h0000FF40);
        apb(1'b1, `RGBMOD_OFS_INT_EN, 2);
        apb(1'b1, `RGBMOD_OFS_CTRL, 3);
        repeat (10) @(posedge pclk);
        win(512);
        chk(cnt_r, 128);
        chk(cnt_g, 510);
        chk(cnt_b, 0);
        chk(irq, 1);
        apb(1'b0, `RGBMOD_OFS_STATUS, 0);
        chk(rd[1], 1);
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_pwm();
        t_off();
        t_pdm();
        test_done();
    end
endmodule // rgbmod_top_test
`default_nettype wire
